// [rtl/adc_gain_offset_output.sv]
// Converter back end top: register slave, sample capture, trim, gain and output.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RULE1: Gain is settable from 0 dB to 6 dB in half-dB steps.
// RULE2: Gain is off after reset; enabling it starts at 0 dB until rewritten.
// RULE3: Each gain step scales the input level that reaches full scale.
// RULE4: Software enables the mode bits before writing a non-zero gain.
// RULE5: When enabled the trim estimates offset within ten millivolts and subtracts it.
// RULE6: While enabled the current correction applies to every sample.
// RULE7: Four-bit period code gives 1M doubling to 2048M cycles; codes above reserved.
// RULE8: The loop period counts sample cycles, so seconds scale with rate.
// RULE9: Hold stops estimate updates but keeps applying the last estimate.
// RULE10: Software sets mode bits, then trim enable and period code.
// RULE11: Two 11-bit sample words leave with one shared forwarded clock.
// RULE12: One bit selects DDR or parallel output.
// RULE13: DDR mode carries two bits per pair per output clock period.
// RULE14: Separate bits double data and clock buffer drive strength.
// RULE15: Parallel mode drives one bit per pin, one word per sample.
// RULE16: The receiver captures parallel words on the forwarded clock rising edge.
// RULE17: Above 150 MSPS the receiver should capture with a delayed input clock.
// RULE18: Positive overdrive gives 7FF offset binary or 3FF twos complement.
// RULE19: Negative overdrive gives 000 offset binary or 400 twos complement.
// RULE20: Multiplexed mode puts both channels on lane B and drives lane A low.
// RULE21: Estimator is a first-order accumulator; gain follows offset removal.
// RULE22: DDR sends even bits on one phase, odd on the other, clock centred.
module adc_gain_offset_output #(
   parameter int TRIM_SHIFT = adc_back_pkg::TRIM_BASE_SHIFT
) (
   input  wire logic                     ref_clk,
   input  wire logic                     resetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output var  logic [31:0]              prdata,
   output var  logic                     pready,
   output var  logic                     pslverr,
   input  wire logic                     conv_clk,
   input  wire adc_back_pkg::raw_t       conv_a,
   input  wire adc_back_pkg::raw_t       conv_b,
   output var  adc_back_pkg::link_pins_t out_pins,
   output var  logic                     data_drive_double,
   output var  logic                     diff_clock_drive_double
);
   import adc_back_pkg::*;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Capture stage state.
   link_in_t sync1_r, sync2_r;
   logic     clk_prev_r;
   logic     take;

   // Register file state.
   ctrl_t       ctrl_r, ctrl_nxt;
   gain_t       gain_r, gain_nxt;
   trim_t       trim_r, trim_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        wr_en, rd_setup, mapped, mode_on, trim_on;
   logic [5:0]  shift;

   // Channel results.
   logic [10:0]        word_w [2];
   logic               valid_w [2];
   logic signed [10:0] est_w [2];
   raw_t               raw_w [2];
   logic [3:0]         gcode_w [2];

   // Converter clock and sample words come from outside; two flops before any use.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
         clk_prev_r <= 1'b0;
      end else begin
         sync1_r <= {conv_clk, conv_a, conv_b};
         sync2_r <= sync1_r;
         clk_prev_r <= sync2_r.clk;
      end
   end

   // A sample is taken on each rising converter clock edge seen after the synchroniser.
   assign take = sync2_r.clk && !clk_prev_r; // see RULE8
   assign raw_w[0] = sync2_r.a;
   assign raw_w[1] = sync2_r.b;

   // APB decode: zero wait states, error on unmapped offsets.
   always_comb begin
      mapped = (paddr == CTRL_OFS) || (paddr == GAIN_OFS)
               || (paddr == TRIM_OFS) || (paddr == STAT_OFS);
      wr_en = psel && penable && pwrite && mapped;
      rd_setup = psel && !penable && !pwrite;
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Mode gating of the gain and trim functions.
   assign mode_on = ctrl_r.digital_mode == MODE_ENABLE;
   assign trim_on = mode_on && trim_r.dc_trim_enable; // see RULE5
   assign shift = 6'(TRIM_SHIFT) + {2'h0, trim_r.dc_trim_loop_period}; // see RULE7

   // Register writes; gain clamps to its top code and reserved periods are ignored.
   always_comb begin
      ctrl_nxt = ctrl_r;
      gain_nxt = gain_r;
      trim_nxt = trim_r;
      if (wr_en && paddr == CTRL_OFS) begin
         ctrl_nxt = ctrl_t'(pwdata[6:0]); // see RULE12
         // Turning the mode on starts gain at 0 dB.
         if (ctrl_nxt.digital_mode == MODE_ENABLE && !mode_on) begin
            gain_nxt = GAIN_RST; // see RULE2
         end
      end
      if (wr_en && paddr == GAIN_OFS) begin
         gain_nxt.gain_a = (pwdata[3:0] > GAIN_MAX_CODE) ? GAIN_MAX_CODE
                           : pwdata[3:0]; // see RULE1
         gain_nxt.gain_b = (pwdata[7:4] > GAIN_MAX_CODE) ? GAIN_MAX_CODE
                           : pwdata[7:4];
      end
      if (wr_en && paddr == TRIM_OFS) begin
         trim_nxt.dc_trim_enable = pwdata[0];
         trim_nxt.dc_trim_hold = pwdata[1]; // see RULE9
         if (pwdata[5:2] <= PERIOD_MAX_CODE) begin
            trim_nxt.dc_trim_loop_period = pwdata[5:2]; // see RULE7
         end
      end
   end

   // Read data is captured in the setup cycle and held through the access.
   always_comb begin
      prdata_nxt = prdata_r;
      if (rd_setup) begin
         case (paddr)
            CTRL_OFS: prdata_nxt = {25'h0000000, ctrl_r};
            GAIN_OFS: prdata_nxt = {24'h000000, gain_r};
            TRIM_OFS: prdata_nxt = {26'h0000000, trim_r};
            STAT_OFS: prdata_nxt = {5'h00, est_w[1], 5'h00, est_w[0]};
            default:  prdata_nxt = 32'h00000000;
         endcase
      end
   end

   // Register file flops.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= CTRL_RST;
         gain_r <= GAIN_RST;
         trim_r <= TRIM_RST;
         prdata_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         gain_r <= gain_nxt;
         trim_r <= trim_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   assign prdata = prdata_r;
   // Drive strength controls go straight to the pad buffers.
   assign data_drive_double = ctrl_r.data_drive_double; // see RULE14
   assign diff_clock_drive_double = ctrl_r.diff_clock_drive_double; // see RULE14
   assign gcode_w[0] = gain_r.gain_a;
   assign gcode_w[1] = gain_r.gain_b;

   // One trim and gain path per channel, each correcting every sample it takes.
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      trim_gain_chan u_chan (
         .ref_clk       (ref_clk),
         .resetn        (resetn),
         .take          (take), // see RULE6
         .raw           (raw_w[ch]),
         .trim_on       (trim_on),
         .hold          (trim_r.dc_trim_hold),
         .shift         (shift),
         .gain_on       (mode_on),
         .gain_code     (gcode_w[ch]),
         .offset_binary (ctrl_r.sample_number_format),
         .word          (word_w[ch]),
         .word_valid    (valid_w[ch]),
         .est           (est_w[ch])
      );
   end

   // Both words go out together with one forwarded clock.
   sample_link_out u_out (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .load    (valid_w[0]), // see RULE11
      .word_a  (word_w[0]),
      .word_b  (word_w[1]),
      .ddr     (ctrl_r.ddr_select),
      .mux     (ctrl_r.mux_mode),
      .pins    (out_pins)
   );

   // Gain codes never exceed the 6 dB step.
   a_gain_range: assert property ( // see RULE1
      gain_r.gain_a <= GAIN_MAX_CODE && gain_r.gain_b <= GAIN_MAX_CODE)
      else $error("gain code above top step");

   // Turning the mode on leaves gain at 0 dB.
   a_gain_enable_zero: assert property ( // see RULE2
      psel && penable && pwrite && paddr == CTRL_OFS
      && pwdata[1:0] == MODE_ENABLE && !mode_on |=> gain_r == GAIN_RST)
      else $error("gain not zero after enable");

   // A reserved loop period never lands in the register.
   a_period_legal: assert property ( // see RULE7
      trim_r.dc_trim_loop_period <= PERIOD_MAX_CODE)
      else $error("reserved loop period stored");

   // With trim off the estimate settles to zero.
   a_trim_off_zero: assert property ( // see RULE5
      (!trim_on) [*3] |-> est_w[0] == 11'sh000 && est_w[1] == 11'sh000)
      else $error("estimate not zero while trim off");

   // Held trim keeps its estimate unchanged.
   a_hold_stable: assert property ( // see RULE9
      (trim_on && trim_r.dc_trim_hold) [*3] |-> $stable(est_w[0]) && $stable(est_w[1]))
      else $error("estimate moved while held");

   // Estimates stay within the trim range.
   a_est_range: assert property ( // see RULE5
      est_w[0] <= OFS_LIMIT && est_w[0] >= -OFS_LIMIT
      && est_w[1] <= OFS_LIMIT && est_w[1] >= -OFS_LIMIT)
      else $error("estimate outside trim range");

   // Positive overdrive clamps to full scale in the selected format.
   a_clamp_pos: assert property ( // see RULE18
      take && sync2_r.a.over_pos |=> word_w[0]
      == ($past(ctrl_r.sample_number_format) ? FS_POS_OB : FS_POS))
      else $error("positive overdrive not clamped");

   // Negative overdrive clamps to negative full scale in the selected format.
   a_clamp_neg: assert property ( // see RULE19
      take && sync2_r.b.over_neg && !sync2_r.b.over_pos |=> word_w[1]
      == ($past(ctrl_r.sample_number_format) ? FS_NEG_OB : FS_NEG))
      else $error("negative overdrive not clamped");

   // Parallel words appear three cycles after the take, clock rising two later.
   a_par_timing: assert property ( // see RULE15
      take && !ctrl_r.ddr_select && !ctrl_r.mux_mode
      |-> ##3 !out_pins.forwarded_sample_clock ##2 out_pins.forwarded_sample_clock)
      else $error("parallel frame timing wrong");

   // In DDR mode data never changes on a clock edge.
   a_ddr_centred: assert property ( // see RULE22
      ctrl_r.ddr_select && $changed(out_pins.forwarded_sample_clock)
      |-> $stable(out_pins.second_channel_bus) && $stable(out_pins.first_channel_bus))
      else $error("DDR data moved on clock edge");

   // Multiplexed mode drives lane A low.
   a_mux_lane_low: assert property ( // see RULE20
      ctrl_r.mux_mode |=> out_pins.first_channel_bus == 11'h000)
      else $error("lane A not low in mux mode");

   // Drive strength pins follow their control bits.
   a_drive_follow: assert property ( // see RULE14
      wr_en && paddr == CTRL_OFS |=> data_drive_double == $past(pwdata[3])
      && diff_clock_drive_double == $past(pwdata[4]))
      else $error("drive strength not applied");

   // Unmapped accesses answer with an error.
   a_apb_unmapped: assert property (
      psel && penable && !mapped |-> pslverr && pready)
      else $error("unmapped access without error");
endmodule
`default_nettype wire

// [rtl/adc_back_pkg.sv]
// Shared constants and types for the converter back end.
package adc_back_pkg;
   localparam int DW = 11;
   localparam int ACC_W = 43;
   // Register byte offsets on the APB slave.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] GAIN_OFS = 8'h04;
   localparam logic [7:0] TRIM_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0C;
   // Mode code that turns on the gain and trim functions.
   localparam logic [1:0] MODE_ENABLE = 2'h3;
   localparam logic [3:0] GAIN_MAX_CODE = 4'hC;
   localparam logic [3:0] PERIOD_MAX_CODE = 4'hB;
   // Loop period code zero is 1M sample cycles, that is two to the twentieth.
   localparam int TRIM_BASE_SHIFT = 20;
   // About 0.98 mV per code, so ten codes cover the 10 mV trim range.
   localparam int OFS_LIMIT = 10;
   localparam int GAIN_FRAC = 12;
   localparam logic [10:0] FS_POS = 11'h3FF;
   localparam logic [10:0] FS_NEG = 11'h400;
   localparam logic [10:0] FS_POS_OB = 11'h7FF;
   localparam logic [10:0] FS_NEG_OB = 11'h000;
   // Output frame phases: one slot of four cycles, two slots when multiplexed.
   localparam logic [2:0] LAST_PHASE_ONE = 3'h3;
   localparam logic [2:0] LAST_PHASE_MUX = 3'h7;
   localparam int PAIRS = 6;
   // Gain factors in half-dB steps, fixed point with twelve fraction bits.
   localparam logic [13:0] GAIN_Q12 [13] = '{
      14'h1000, 14'h10F3, 14'h11F4, 14'h1305, 14'h1425, 14'h1556, 14'h169A,
      14'h17F1, 14'h195C, 14'h1ADC, 14'h1C74, 14'h1E23, 14'h1FED};

   typedef struct packed {
      logic       mux_mode;
      logic       sample_number_format;
      logic       diff_clock_drive_double;
      logic       data_drive_double;
      logic       ddr_select;
      logic [1:0] digital_mode;
   } ctrl_t;

   typedef struct packed {
      logic [3:0] gain_b;
      logic [3:0] gain_a;
   } gain_t;

   typedef struct packed {
      logic [3:0] dc_trim_loop_period;
      logic       dc_trim_hold;
      logic       dc_trim_enable;
   } trim_t;

   typedef struct packed {
      logic [10:0] code;
      logic        over_pos;
      logic        over_neg;
   } raw_t;

   typedef struct packed {
      logic clk;
      raw_t a;
      raw_t b;
   } link_in_t;

   typedef struct packed {
      logic        forwarded_sample_clock;
      logic [10:0] second_channel_bus;
      logic [10:0] first_channel_bus;
   } link_pins_t;

   localparam ctrl_t CTRL_RST = '0;
   localparam gain_t GAIN_RST = '0;
   localparam trim_t TRIM_RST = '0;
endpackage

// [rtl/trim_gain_chan.sv]
// One channel of offset trim, digital gain, clamping and number format.
`timescale 1ns/10ps
`default_nettype none
module trim_gain_chan (
   input  wire logic                     ref_clk,
   input  wire logic                     resetn,
   input  wire logic                     take,
   input  wire adc_back_pkg::raw_t       raw,
   input  wire logic                     trim_on,
   input  wire logic                     hold,
   input  wire logic [5:0]               shift,
   input  wire logic                     gain_on,
   input  wire logic [3:0]               gain_code,
   input  wire logic                     offset_binary,
   output var  logic [10:0]              word,
   output var  logic                     word_valid,
   output var  logic signed [10:0]       est
);
   import adc_back_pkg::*;

   logic signed [ACC_W-1:0] acc_r, acc_nxt, est_full;
   logic signed [10:0]      x, est_c, sat;
   logic signed [11:0]      corr;
   logic signed [26:0]      prod, scaled;
   logic [3:0]              gidx;
   logic [10:0]             word_r, word_nxt;
   logic                    valid_r;
   logic signed [10:0]      est_r;

   // Low-pass estimate with weight one over the loop period, then gain and clamp.
   always_comb begin
      x = signed'({~raw.code[10], raw.code[9:0]});
      est_full = acc_r >>> shift;
      if (est_full > OFS_LIMIT) begin
         est_c = 11'(OFS_LIMIT);
      end else if (est_full < -OFS_LIMIT) begin
         est_c = -11'(OFS_LIMIT);
      end else begin
         est_c = est_full[10:0];
      end
      acc_nxt = acc_r;
      if (!trim_on) begin
         acc_nxt = '0;
      end else if (take && !hold) begin
         acc_nxt = acc_r + ACC_W'(x) - est_full; // see RULE21
      end
      corr = 12'(x) - 12'(est_c); // see RULE5
      gidx = (gain_on && gain_code <= GAIN_MAX_CODE) ? gain_code : 4'h0;
      prod = corr * signed'({1'b0, GAIN_Q12[gidx]}); // see RULE3
      scaled = prod >>> GAIN_FRAC;
      if (raw.over_pos || scaled > 27'sd1023) begin
         sat = signed'(FS_POS); // see RULE18
      end else if (raw.over_neg || scaled < -27'sd1024) begin
         sat = signed'(FS_NEG); // see RULE19
      end else begin
         sat = scaled[10:0];
      end
      word_nxt = take ? (offset_binary ? {~sat[10], sat[9:0]} : sat) : word_r;
   end

   // Registers of the trim loop and the output word.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         acc_r <= '0;
         word_r <= '0;
         valid_r <= 1'b0;
         est_r <= '0;
      end else begin
         acc_r <= acc_nxt;
         word_r <= word_nxt;
         valid_r <= take;
         est_r <= trim_on ? est_c : 11'sh000;
      end
   end

   assign word = word_r;
   assign word_valid = valid_r;
   assign est = est_r;
endmodule
`default_nettype wire

// [rtl/sample_link_out.sv]
// Output serializer: parallel or DDR words, multiplexing and forwarded clock.
`timescale 1ns/10ps
`default_nettype none
module sample_link_out (
   input  wire logic                     ref_clk,
   input  wire logic                     resetn,
   input  wire logic                     load,
   input  wire logic [10:0]              word_a,
   input  wire logic [10:0]              word_b,
   input  wire logic                     ddr,
   input  wire logic                     mux,
   output var  adc_back_pkg::link_pins_t pins
);
   import adc_back_pkg::*;

   link_pins_t  pins_r, pins_nxt;
   logic [10:0] wa_r, wa_nxt, wb_r, wb_nxt;
   logic [2:0]  phase_r, phase_nxt;
   logic        run_r, run_nxt;
   logic        ddr_r, ddr_nxt, mux_r, mux_nxt;
   logic [11:0] ext_a, ext_b;
   logic [5:0]  ev_a, od_a, ev_b, od_b;

   // Lane B carries channel A then channel B when multiplexed.
   assign ext_a = {1'b0, wa_r};
   assign ext_b = {1'b0, (mux_r && !phase_r[2]) ? wa_r : wb_r};

   // Even bits go out on one clock phase, odd bits on the other.
   for (genvar k = 0; k < PAIRS; k++) begin : g_pair
      assign ev_a[k] = ext_a[2*k];
      assign od_a[k] = ext_a[2*k+1];
      assign ev_b[k] = ext_b[2*k];
      assign od_b[k] = ext_b[2*k+1];
   end

   // Frame sequencing and pin values; DDR clock edges fall mid-way between data changes, parallel clock falls with them.
   always_comb begin
      wa_nxt = wa_r;
      wb_nxt = wb_r;
      phase_nxt = phase_r;
      run_nxt = run_r;
      pins_nxt = pins_r;
      ddr_nxt = ddr_r;
      mux_nxt = mux_r;
      // DDR and lane B selection are latched per frame; lane A low-drive follows the live mux input mid-frame.
      if (load) begin
         wa_nxt = word_a;
         wb_nxt = word_b;
         phase_nxt = 3'h0;
         run_nxt = 1'b1;
         ddr_nxt = ddr;
         mux_nxt = mux;
      end else if (run_r) begin
         phase_nxt = phase_r + 3'h1;
         run_nxt = phase_r != (mux_r ? LAST_PHASE_MUX : LAST_PHASE_ONE);
      end
      if (run_r) begin
         case (phase_r[1:0])
            2'h0: begin
               pins_nxt.forwarded_sample_clock = 1'b0;
               if (ddr_r) begin
                  pins_nxt.first_channel_bus = {5'h00, ev_a}; // see RULE22
                  pins_nxt.second_channel_bus = {5'h00, ev_b};
               end else begin
                  pins_nxt.first_channel_bus = wa_r; // see RULE15
                  pins_nxt.second_channel_bus = ext_b[10:0];
               end
            end
            2'h1: pins_nxt.forwarded_sample_clock = ddr_r; // see RULE13
            2'h2: begin
               // The clock stays high here so the DDR fall lands mid-way in the odd bits.
               pins_nxt.forwarded_sample_clock = 1'b1;
               if (ddr_r) begin
                  pins_nxt.first_channel_bus = {5'h00, od_a}; // see RULE22
                  pins_nxt.second_channel_bus = {5'h00, od_b};
               end
            end
            2'h3: pins_nxt.forwarded_sample_clock = ~ddr_r;
            default: pins_nxt.forwarded_sample_clock = 1'b0;
         endcase
      end else if (ddr) begin
         // An idle DDR link parks its clock low, so no frame starts on a clock fall.
         pins_nxt.forwarded_sample_clock = 1'b0; // see RULE22
      end
      if (mux) begin
         pins_nxt.first_channel_bus = '0; // see RULE20
      end
   end

   // Registers of the output stage.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pins_r <= '0;
         wa_r <= '0;
         wb_r <= '0;
         phase_r <= '0;
         run_r <= 1'b0;
         ddr_r <= 1'b0;
         mux_r <= 1'b0;
      end else begin
         pins_r <= pins_nxt;
         wa_r <= wa_nxt;
         wb_r <= wb_nxt;
         phase_r <= phase_nxt;
         run_r <= run_nxt;
         ddr_r <= ddr_nxt;
         mux_r <= mux_nxt;
      end
   end

   assign pins = pins_r;
endmodule
`default_nettype wire

// [verif/sample_receiver.sv]
// Receiver model that rebuilds sample words from the output pins.
`timescale 1ns/10ps
`default_nettype none
module sample_receiver (
   input  wire adc_back_pkg::link_pins_t pins,
   input  wire logic                     ddr,
   input  wire logic                     mux,
   output var  logic [10:0]              got_a,
   output var  logic [10:0]              got_b,
   output var  int                       n
);
   import adc_back_pkg::*;
   logic [5:0] ev_a;
   logic [5:0] ev_b;
   logic       slot_b = 1'b0;
   real        t_up = 0.0;
   initial n = 0;

   // Puts even and odd halves back into one word.
   function automatic logic [10:0] weave(input logic [5:0] e, input logic [5:0] o);
      logic [11:0] r;
      for (int k = 0; k < 6; k++) begin
         r[2*k] = e[k];
         r[2*k+1] = o[k];
      end
      return r[10:0];
   endfunction

   // Parallel and multiplexed words are taken on the forwarded clock rise; the rate stays far below 150 MSPS.
   always @(posedge pins.forwarded_sample_clock) begin
      t_up = $realtime;
      ev_a <= pins.first_channel_bus[5:0];
      ev_b <= pins.second_channel_bus[5:0];
      if (mux && !slot_b) begin
         got_a <= pins.second_channel_bus;
         slot_b <= 1'b1;
      end else if (mux) begin
         got_b <= pins.second_channel_bus;
         slot_b <= 1'b0;
         n <= n + 1;
      end else if (!ddr) begin
         got_a <= pins.first_channel_bus;
         got_b <= pins.second_channel_bus;
         n <= n + 1;
      end
   end

   // A fall after a long high starts a frame; a short one closes a DDR word unless multiplexed.
   always @(negedge pins.forwarded_sample_clock) begin
      if ($realtime - t_up > 35.0) begin
         slot_b <= 1'b0;
      end else if (ddr && !mux) begin
         got_a <= weave(ev_a, pins.first_channel_bus[5:0]);
         got_b <= weave(ev_b, pins.second_channel_bus[5:0]);
         n <= n + 1;
      end
   end
endmodule
`default_nettype wire

// [verif/adc_gain_offset_output_tb.sv]
// Self-checking bench for the converter back end.
`timescale 1ns/10ps
`default_nettype none
module adc_gain_offset_output_tb;
   import adc_back_pkg::*;
   logic        ref_clk = 0, resetn = 0, conv_clk = 0, ddr = 0, mux = 0;
   logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, ddd, cdd;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   raw_t        conv_a = '0, conv_b = '0;
   link_pins_t  pins;
   logic [10:0] got_a, got_b;
   int          n, mismatches = 0, cmp_count = 0;

   adc_gain_offset_output #(.TRIM_SHIFT(4)) DUT (.ref_clk(ref_clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_clk(conv_clk),
      .conv_a(conv_a), .conv_b(conv_b), .out_pins(pins), .data_drive_double(ddd),
      .diff_clock_drive_double(cdd));
   sample_receiver rx (.pins(pins), .ddr(ddr), .mux(mux), .got_a(got_a), .got_b(got_b),
      .n(n));

   // The converter clock runs free and unrelated to the system clock.
   initial forever #5 ref_clk = ~ref_clk;
   initial forever #62.5 conv_clk = ~conv_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // Data change mid-period, far from the converter clock rise.
   task automatic send(input logic [12:0] a, input logic [12:0] b);
      int n0;
      @(negedge conv_clk);
      @(posedge ref_clk);
      conv_a <= a;
      conv_b <= b;
      @(posedge conv_clk);
      n0 = n;
      for (int i = 0; i < 40 && n == n0; i++) @(posedge ref_clk);
      @(posedge ref_clk);
   endtask

   task automatic t_regs();
      for (int i = 0; i < 3; i++) begin
         apb(0, 8'(4 * i), 0);
         chk(rd, 0);
      end
      apb(0, 8'h10, 0);
      chk({err, rd[30:0]}, 32'h80000000);
   endtask

   task automatic t_fmt();
      for (int f = 0; f < 2; f++) begin
         apb(1, CTRL_OFS, f ? 32'h28 : 32'h10);
         send({11'h500, 2'b10}, {11'h123, 2'b01});
         chk({got_a, got_b}, f ? {FS_POS_OB, FS_NEG_OB} : {FS_POS, FS_NEG});
         chk({ddd, cdd}, f ? 2'b10 : 2'b01);
         send({11'h500, 2'b00}, {11'h123, 2'b11});
         chk({got_a, got_b}, {11'h500 ^ (f ? 11'h0 : 11'h400), f ? FS_POS_OB : FS_POS});
      end
   endtask

   task automatic t_lanes();
      ddr <= 1;
      apb(1, CTRL_OFS, 32'h04);
      send({11'h2AB, 2'b00}, {11'h555, 2'b00});
      chk({got_a, got_b}, {11'h6AB, 11'h155});
      ddr <= 0;
      mux <= 1;
      apb(1, CTRL_OFS, 32'h40);
      send({11'h0F0, 2'b00}, {11'h70F, 2'b00});
      chk({got_a, got_b}, {11'h4F0, 11'h30F});
      chk(pins.first_channel_bus, 0);
      mux <= 0;
   endtask

   task automatic t_gain();
      apb(1, CTRL_OFS, {30'h0, MODE_ENABLE});
      apb(0, GAIN_OFS, 0);
      chk(rd, 0);
      send({11'h464, 2'b00}, {11'h39C, 2'b00});
      chk({got_a, got_b}, {11'h064, 11'h79C});
      apb(1, GAIN_OFS, 32'hFC);
      apb(0, GAIN_OFS, 0);
      chk(rd, 32'hCC);
      send({11'h658, 2'b00}, {11'h1A8, 2'b00});
      chk({got_a, got_b}, {FS_POS, FS_NEG});
   endtask

   task automatic t_trim();
      apb(1, GAIN_OFS, 0);
      apb(1, TRIM_OFS, 32'h31);
      apb(0, TRIM_OFS, 0);
      chk(rd, 32'h01);
      send({11'h420, 2'b00}, {11'h420, 2'b00});
      repeat (40) @(posedge conv_clk);
      apb(0, STAT_OFS, 0);
      chk(rd, 32'h000A000A);
      send({11'h420, 2'b00}, {11'h420, 2'b00});
      chk({got_a, got_b}, {11'h016, 11'h016});
      apb(1, TRIM_OFS, 32'h03);
      send({11'h430, 2'b00}, {11'h3F0, 2'b00});
      chk({got_a, got_b}, {11'h026, 11'h7E6});
      repeat (20) @(posedge conv_clk);
      apb(0, STAT_OFS, 0);
      chk(rd, 32'h000A000A);
   endtask

   task automatic give_verdict();
      $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence after a 12-cycle reset.
   initial begin
      repeat (12) @(posedge ref_clk);
      resetn <= 1;
      t_regs();
      t_fmt();
      t_lanes();
      t_gain();
      t_trim();
      give_verdict();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #100000;
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire
